/* File: core/pin_mux_pkg.sv */
package pin_mux_pkg;
    localparam logic [7:0] MP_PIN_OFFSET = 8'h33;
    localparam logic [7:0] RSVD_SLOT_OFFSET = 8'h34;
    localparam logic [7:0] SOUT_PIN_OFFSET = 8'h35;
    localparam logic [7:0] SIN_PIN_OFFSET = 8'h36;
    localparam int MP_FUNC_LSB = 2;
    localparam int MP_IN_BIT = 1;
    localparam int MP_GPO_BIT = 0;
    localparam int SOUT_KEEP_BIT = 4;
    localparam int SOUT_SEL_LSB = 1;
    localparam int SOUT_GPO_BIT = 0;
    localparam int SIN_SEL_LSB = 1;
    localparam int SIN_IN_BIT = 0;
    localparam logic [7:0] MP_RESET = 8'h00;
    localparam logic [7:0] SOUT_RESET = 8'h12;
    localparam logic [7:0] SIN_RESET = 8'h02;
    localparam logic [7:0] RSVD_SLOT_RESET = 8'h00;

    typedef enum logic [3:0] {
        MP_OFF = 4'b0000,
        MP_INPUT = 4'b0001,
        MP_GEN_IN = 4'b0010,
        MP_GEN_OUT = 4'b0011,
        MP_IRQ1 = 4'b0100,
        MP_IRQ2 = 4'b0101,
        MP_REC_WCLK = 4'b0111,
        MP_SEC_BCLK = 4'b1000,
        MP_SEC_WCLK = 4'b1001,
        MP_MOD_CLK = 4'b1010,
        MP_SEC_DATA = 4'b1011
    } mp_func_e;

    typedef enum logic [2:0] {
        SO_OFF = 3'b000,
        SO_PRIMARY = 3'b001,
        SO_GEN_OUT = 3'b010,
        SO_CLK_OUT = 3'b011,
        SO_IRQ1 = 3'b100,
        SO_IRQ2 = 3'b101,
        SO_SEC_BCLK = 3'b110,
        SO_SEC_WCLK = 3'b111
    } sout_sel_e;

    typedef enum logic [1:0] {
        SI_OFF = 2'b00,
        SI_ENABLED = 2'b01,
        SI_GEN_IN = 2'b10,
        SI_RSVD = 2'b11
    } sin_sel_e;

    // internal sources that may be routed out to a pin
    typedef struct packed {
        logic interrupt_line_one;
        logic interrupt_line_two;
        logic record_word_clock;
        logic sec_bit_clock;
        logic sec_word_clock;
        logic record_modulator_clock;
        logic sec_data_out;
        logic primary_data_out;
        logic clock_output;
    } pin_src_s;
endpackage

/* File: core/codec_pin_function_mux.sv */
`timescale 1ns/1ps
module codec_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire pin_src_s src,
    input wire logic mp_pin_in,
    output logic mp_pin_out,
    output logic mp_pin_oe,
    output logic mp_pin_in_en,
    output logic mp_audio_in,
    output logic mp_audio_in_valid,
    output logic sout_pin_out,
    output logic sout_pin_oe,
    output logic sout_keeper_en,
    input wire logic sin_pin_in,
    output logic sin_pin_in_en,
    output logic sin_audio_in
);

    logic [7:0] mp_ctrl_ff;
    logic [7:0] sout_ctrl_ff;
    logic [7:0] sin_ctrl_ff;
    logic mp_level;
    logic sin_level;
    logic [3:0] mp_func;
    logic [2:0] sout_sel;
    logic [1:0] sin_sel;
    logic mp_drv;
    logic mp_oe_c;
    logic mp_ie_c;
    logic so_drv;
    logic so_oe_c;
    logic si_ie_c;
    logic wr_mp;
    logic wr_so;
    logic wr_si;
    logic [7:0] nxt_rdata;

    // true for the function codes that switch the output buffer on
    function automatic logic mp_output_code(input logic [3:0] func);
        logic hit;
        hit = 1'b0;
        unique case (func)
            MP_GEN_OUT,
            MP_IRQ1,
            MP_IRQ2,
            MP_REC_WCLK,
            MP_SEC_BCLK,
            MP_SEC_WCLK,
            MP_MOD_CLK,
            MP_SEC_DATA:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // true for the function codes that switch the input buffer on
    function automatic logic mp_input_code(input logic [3:0] func);
        logic hit;
        hit = 1'b0;
        unique case (func)
            MP_INPUT,
            MP_GEN_IN:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // true only for the function code that hands the pin to the audio logic
    function automatic logic mp_audio_code(input logic [3:0] func);
        return func == MP_INPUT;
    endfunction

    // true for the serial input selects that keep the input buffer on
    function automatic logic sin_input_code(input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            SI_ENABLED,
            SI_GEN_IN:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // puts a live level, or a zero, into one bit position of a register word
    function automatic logic [7:0] with_level(input logic [7:0] word, input int pos,
        input logic level);
        logic [7:0] res;
        res = word;
        res[pos] = level;
        return res;
    endfunction

    assign mp_func = mp_ctrl_ff[MP_FUNC_LSB +: 4];
    assign sout_sel = sout_ctrl_ff[SOUT_SEL_LSB +: 3];
    assign sin_sel = sin_ctrl_ff[SIN_SEL_LSB +: 2];

    // write decode; the reserved slot and unmapped addresses have no storage
    assign wr_mp = reg_wr_en && (reg_addr == MP_PIN_OFFSET);
    assign wr_so = reg_wr_en && (reg_addr == SOUT_PIN_OFFSET);
    assign wr_si = reg_wr_en && (reg_addr == SIN_PIN_OFFSET);

    // multipurpose pin register; the input level bit is not stored
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mp_ctrl_ff <= MP_RESET;
        end
        else if (wr_mp)
        begin
            mp_ctrl_ff <= with_level(reg_wdata, MP_IN_BIT, 1'b0);
        end
    end

    // serial output pin register, all bits stored
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sout_ctrl_ff <= SOUT_RESET;
        end
        else if (wr_so)
        begin
            sout_ctrl_ff <= reg_wdata;
        end
    end

    // serial input pin register; the live level bit is not stored
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sin_ctrl_ff <= SIN_RESET;
        end
        else if (wr_si)
        begin
            sin_ctrl_ff <= with_level(reg_wdata, SIN_IN_BIT, 1'b0);
        end
    end

    // multipurpose pin buffer enables
    always_comb
    begin
        mp_oe_c = mp_output_code(mp_func);
        mp_ie_c = mp_input_code(mp_func);
    end

    // multipurpose pin output source
    always_comb
    begin
        mp_drv = 1'b0;
        unique case (mp_func)
            MP_GEN_OUT:
            begin
                mp_drv = mp_ctrl_ff[MP_GPO_BIT];
            end
            MP_IRQ1:
            begin
                mp_drv = src.interrupt_line_one;
            end
            MP_IRQ2:
            begin
                mp_drv = src.interrupt_line_two;
            end
            MP_REC_WCLK:
            begin
                mp_drv = src.record_word_clock;
            end
            MP_SEC_BCLK:
            begin
                mp_drv = src.sec_bit_clock;
            end
            MP_SEC_WCLK:
            begin
                mp_drv = src.sec_word_clock;
            end
            MP_MOD_CLK:
            begin
                mp_drv = src.record_modulator_clock;
            end
            MP_SEC_DATA:
            begin
                mp_drv = src.sec_data_out;
            end
            default:
            begin
                mp_drv = 1'b0;
            end
        endcase
    end

    // serial output pin source
    always_comb
    begin
        so_oe_c = (sout_sel != SO_OFF);
        so_drv = 1'b0;
        unique case (sout_sel)
            SO_OFF:
            begin
                so_drv = 1'b0;
            end
            SO_PRIMARY:
            begin
                so_drv = src.primary_data_out;
            end
            SO_GEN_OUT:
            begin
                so_drv = sout_ctrl_ff[SOUT_GPO_BIT];
            end
            SO_CLK_OUT:
            begin
                so_drv = src.clock_output;
            end
            SO_IRQ1:
            begin
                so_drv = src.interrupt_line_one;
            end
            SO_IRQ2:
            begin
                so_drv = src.interrupt_line_two;
            end
            SO_SEC_BCLK:
            begin
                so_drv = src.sec_bit_clock;
            end
            SO_SEC_WCLK:
            begin
                so_drv = src.sec_word_clock;
            end
        endcase
    end

    // serial input pin buffer enable; the reserved select keeps it off
    always_comb
    begin
        si_ie_c = sin_input_code(sin_sel);
    end

    // levels seen behind the input buffers; a powered-down buffer reads low
    assign mp_level = mp_ie_c & mp_pin_in;
    assign sin_level = si_ie_c & sin_pin_in;

    // multipurpose pin side outputs
    always_comb
    begin
        mp_pin_out = mp_drv;
        mp_pin_oe = mp_oe_c;
        mp_pin_in_en = mp_ie_c;
        mp_audio_in = mp_audio_code(mp_func) & mp_pin_in;
        mp_audio_in_valid = mp_audio_code(mp_func);
    end

    // serial pin side outputs
    always_comb
    begin
        sout_pin_out = so_drv;
        sout_pin_oe = so_oe_c;
        sout_keeper_en = ~sout_ctrl_ff[SOUT_KEEP_BIT];
        sin_pin_in_en = si_ie_c;
        sin_audio_in = (sin_sel == SI_ENABLED) & sin_pin_in;
    end

    // read word by address; live levels fill the read-only bits
    always_comb
    begin
        nxt_rdata = RSVD_SLOT_RESET;
        unique case (reg_addr)
            MP_PIN_OFFSET:
            begin
                nxt_rdata = with_level(mp_ctrl_ff, MP_IN_BIT, mp_level);
            end
            SOUT_PIN_OFFSET:
            begin
                nxt_rdata = sout_ctrl_ff;
            end
            SIN_PIN_OFFSET:
            begin
                nxt_rdata = with_level(sin_ctrl_ff, SIN_IN_BIT, sin_level);
            end
            default:
            begin
                nxt_rdata = RSVD_SLOT_RESET;
            end
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata <= nxt_rdata;
        end
    end

endmodule

/* File: sim/pin_mux_checker.sv */
`timescale 1ns/1ps
module pin_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire pin_src_s src,
    input wire logic mp_pin_out,
    input wire logic mp_pin_oe,
    input wire logic mp_pin_in_en,
    input wire logic sout_pin_out,
    input wire logic sout_pin_oe,
    input wire logic sout_keeper_en,
    input wire logic sin_pin_in,
    input wire logic sin_pin_in_en
);
    logic wr_mp, wr_so, wr_si;
    assign wr_mp = reg_wr_en && reg_addr == MP_PIN_OFFSET;
    assign wr_so = reg_wr_en && reg_addr == SOUT_PIN_OFFSET;
    assign wr_si = reg_wr_en && reg_addr == SIN_PIN_OFFSET;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_sin_rd;
        reg_rd_en && reg_addr == SIN_PIN_OFFSET;
    endsequence
    a_mp_off: assert property (wr_mp && reg_wdata[5:2] == 4'h0 |=> !mp_pin_oe && !mp_pin_in_en)
        else $error("mp pin not off");
    a_mp_gpo: assert property (wr_mp && reg_wdata[5:2] == 4'h3 |=> mp_pin_oe
        && mp_pin_out == $past(reg_wdata[0])) else $error("mp pin gpo wrong");
    a_mp_irq: assert property (wr_mp && reg_wdata[5:2] == 4'h4
        |=> mp_pin_out == src.interrupt_line_one) else $error("mp pin irq wrong");
    a_keeper_bit: assert property (wr_so |=> sout_keeper_en != $past(reg_wdata[4]))
        else $error("keeper wrong");
    a_sout_off: assert property (wr_so && reg_wdata[3:1] == 3'h0 |=> !sout_pin_oe)
        else $error("sout not off");
    a_sout_gpo: assert property (wr_so && reg_wdata[3:1] == 3'h2 |=> sout_pin_oe
        && sout_pin_out == $past(reg_wdata[0])) else $error("sout gpo wrong");
    a_sin_gen: assert property (wr_si && reg_wdata[2:1] == 2'h2 |=> sin_pin_in_en)
        else $error("sin input off");
    a_sin_read: assert property (s_sin_rd |=> reg_rdata[0] == $past(sin_pin_in && sin_pin_in_en))
        else $error("sin read wrong");
endmodule
bind codec_pin_function_mux pin_mux_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .src(src), .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe),
    .mp_pin_in_en(mp_pin_in_en), .sout_pin_out(sout_pin_out), .sout_pin_oe(sout_pin_oe),
    .sout_keeper_en(sout_keeper_en), .sin_pin_in(sin_pin_in), .sin_pin_in_en(sin_pin_in_en));

/* File: sim/pin_side_model.sv */
`timescale 1ns/1ps
module pin_side_model
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    output pin_src_s src,
    output logic mp_drive,
    output logic sin_pin_in
);
    logic [10:0] cnt_ff;
    // sources and far-side levels are bits of a counter that steps by 11'h2cb every cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 11'h5a5;
        end
        else
        begin
            cnt_ff <= cnt_ff + 11'h2cb;
        end
    end
    assign src = cnt_ff[8:0];
    assign mp_drive = cnt_ff[9];
    assign sin_pin_in = cnt_ff[10];
endmodule

/* File: sim/codec_pin_function_mux_test.sv */
`timescale 1ns/1ps
module codec_pin_function_mux_test;
    import pin_mux_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sv;
    logic mp_drive, mp_pin_in, mp_pin_out, mp_pin_oe, mp_pin_in_en, mp_audio_in, mp_audio_in_valid;
    logic sout_pin_out, sout_pin_oe, sout_keeper_en, sin_pin_in, sin_pin_in_en, sin_audio_in;
    logic [15:0] mv, oe_m = 16'h0fb8, in_m = 16'h0006;
    pin_src_s src;
    int err_count = 0, checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    // a driven pin reads back its own level
    assign mp_pin_in = mp_pin_oe ? mp_pin_out : mp_drive;
    assign mv = {4'h0, src.sec_data_out, src.record_modulator_clock, src.sec_word_clock,
        src.sec_bit_clock, src.record_word_clock, 1'b0, src.interrupt_line_two,
        src.interrupt_line_one, reg_wdata[0], 3'b000};
    assign sv = {src.sec_word_clock, src.sec_bit_clock, src.interrupt_line_two,
        src.interrupt_line_one, src.clock_output, reg_wdata[0], src.primary_data_out, 1'b0};
    pin_side_model model_u (.clk_sys(clk_sys), .rst_n(rst_n), .src(src), .mp_drive(mp_drive),
        .sin_pin_in(sin_pin_in));
    codec_pin_function_mux dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .src(src), .mp_pin_in(mp_pin_in), .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe),
        .mp_pin_in_en(mp_pin_in_en), .mp_audio_in(mp_audio_in),
        .mp_audio_in_valid(mp_audio_in_valid), .sout_pin_out(sout_pin_out),
        .sout_pin_oe(sout_pin_oe), .sout_keeper_en(sout_keeper_en), .sin_pin_in(sin_pin_in),
        .sin_pin_in_en(sin_pin_in_en), .sin_audio_in(sin_audio_in));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        err_count += int'(g !== e);
        if (g !== e)
            $display("ERROR %s expected %h seen %h", w, e, g);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk_sys);
        #2 reg_wr_en = 1'b0;
        @(posedge clk_sys);
        #2;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk_sys);
        #2 reg_rd_en = 1'b0;
        chk(w, e, reg_rdata);
        @(posedge clk_sys);
        #2;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #2 rst_n = 1'b1;
        chk("reset pins", 8'h0a, {4'h0, sout_pin_oe, sout_keeper_en, sin_pin_in_en, mp_pin_oe});
        rd(MP_PIN_OFFSET, 8'h00, "mp reset");
        rd(SOUT_PIN_OFFSET, 8'h12, "sout reset");
        rd(SIN_PIN_OFFSET, {7'h01, sin_pin_in}, "sin reset");
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00, "unmapped");
        rd(RSVD_SLOT_OFFSET, RSVD_SLOT_RESET, "rsvd slot");
        $display("test reset done");
        for (int i = 0; i < 32; i++)
        begin
            wr(MP_PIN_OFFSET, {2'b00, i[4:1], 1'b1, i[0]});
            chk("mp pin", {3'h0, i[4:1] == 4'h1 && mp_drive, i[4:1] == 4'h1, oe_m[i[4:1]],
                in_m[i[4:1]], mv[i[4:1]]}, {3'h0, mp_audio_in, mp_audio_in_valid, mp_pin_oe,
                mp_pin_in_en,
                mp_pin_out & mp_pin_oe});
            rd(MP_PIN_OFFSET, {2'b00, i[4:1], mp_drive & in_m[i[4:1]], i[0]}, "mp reg");
        end
        $display("test mp done");
        for (int i = 0; i < 32; i++)
        begin
            wr(SOUT_PIN_OFFSET, {3'b000, i[4:0]});
            chk("sout pin", {5'h0, ~i[4], i[3:1] != 3'h0, sv[i[3:1]]}, {5'h0, sout_keeper_en,
                sout_pin_oe, sout_pin_out & sout_pin_oe});
            rd(SOUT_PIN_OFFSET, {3'b000, i[4:0]}, "sout reg");
        end
        $display("test sout done");
        for (int i = 0; i < 6; i++)
        begin
            wr(SIN_PIN_OFFSET, {5'h00, i[2:1], 1'b1});
            chk("sin pin", {6'h0, i[2:1] != 2'h0, i[2:1] == 2'h1 && sin_pin_in}, {6'h0,
                sin_pin_in_en, sin_audio_in});
            rd(SIN_PIN_OFFSET, {5'h00, i[2:1], sin_pin_in && i[2:1] != 2'h0}, "sin reg");
        end
        $display("test sin done");
        wrap_up();
    end
endmodule
